// ==== verilog/secp_dev.sv ====
// How it works
// - Opcodes 06 set, 04 clear, 05 status read
// - Opcodes 01 status write, 03 read, 02 write
// - Opcodes 83/82 split by address bit ten
// - Unknown opcode ignores rest until next select
// - Master sends latch set before each write
// - Latch set command sets the write latch
// - Latch commands act at chip select rise
// - Latch cleared by reset, clear, write completion
// - Status read always allowed, repeats while selected
// - Master polls busy before new commands
// - Busy is one during self-timed cycles
// - Latch zero rejects all writes
// - Protect bits refuse writes to guarded region
// - Lock bit plus low pin blocks status write
// - Status write keeps bits 6,5,4,1,0
// - Status write is opcode plus one byte
// - Select must rise right after eighth bit
// - Valid status write starts timed busy cycle
// - Old protect values hold until cycle end
// - Lock bit zero ignores protect pin
// - Hardware lock entered last-event, left on pin high
// - Protect codes quarter, half, whole array
// - Modes 0 and 3, rise sample, fall drive
`timescale 1ns/1ns
module secp_dev
    import secp_pkg::*;
#(
    parameter int unsigned TW_CYC = TW_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Serial link
    secp_if.dev              link,
    // Status view
    output logic [7:0]       status_byte,
    output logic             hw_lock_mode,
    // Array and identification requests
    output logic             arr_rd_go,
    output logic             arr_wr_go,
    output logic [23:0]      arr_addr,
    output logic             id_go,
    output logic [1:0]       id_kind
);

    if (TW_CYC < 1) begin : g_bad_tw
        $error("TW_CYC must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic [3:0]  pin_meta_reg;
    logic [3:0]  pin_sync_reg;
    logic [3:0]  pin_prev_reg;

    // Order: cs_n, sck, mosi, wp_n
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta_reg <= 4'hd;
            pin_sync_reg <= 4'hd;
            pin_prev_reg <= 4'hd;
        end else begin
            pin_meta_reg <= {link.cs_n, link.sck, link.mosi, link.wp_n};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    logic        cs_s;
    logic        mosi_s;
    logic        wp_s;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_fall;
    logic        cs_rise;

    assign cs_s     = pin_sync_reg[3];
    assign mosi_s   = pin_sync_reg[1];
    assign wp_s     = pin_sync_reg[0];
    assign sck_rise = ~cs_s & pin_sync_reg[2] & ~pin_prev_reg[2];
    assign sck_fall = ~cs_s & ~pin_sync_reg[2] & pin_prev_reg[2];
    assign cs_fall  = ~cs_s & pin_prev_reg[3];
    assign cs_rise  = cs_s & ~pin_prev_reg[3];

    ////////////////////////////////////////////////////////////////////////
    // Bit and byte assembly
    secp_state_t state_reg;
    logic [2:0]  bit_cnt_reg;
    logic [1:0]  addr_cnt_reg;
    logic [1:0]  data_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  op_reg;
    logic [23:0] addr_reg;
    logic [7:0]  data_reg;
    logic        at_byte_reg;
    logic        byte_end;
    logic [7:0]  byte_in;
    logic [23:0] addr_full;

    assign byte_end  = sck_rise & (bit_cnt_reg == 3'h7);
    assign byte_in   = {shift_reg[6:0], mosi_s};
    assign addr_full = {addr_reg[15:0], byte_in};

    // Shifting, counting and field capture
    always_ff @(posedge clk_sys) begin
        if (rst || cs_fall) begin
            bit_cnt_reg  <= 3'h0;
            addr_cnt_reg <= 2'h0;
            data_cnt_reg <= 2'h0;
            shift_reg    <= 8'h00;
            at_byte_reg  <= 1'b0;
        end else if (sck_rise) begin
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            at_byte_reg <= (bit_cnt_reg == 3'h7);
            if (byte_end && state_reg == ST_OPC) begin
                op_reg <= byte_in;
            end
            if (byte_end && state_reg == ST_ADDR) begin
                addr_reg     <= addr_full;
                addr_cnt_reg <= addr_cnt_reg + 2'h1;
            end
            if (byte_end && state_reg == ST_DATA) begin
                if (data_cnt_reg == 2'h0) begin
                    data_reg <= byte_in;
                end
                if (data_cnt_reg != 2'h2) begin
                    data_cnt_reg <= data_cnt_reg + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protocol state machine
    logic        busy_reg;
    logic        addr_done;

    assign addr_done = byte_end && (addr_cnt_reg == 2'(ADDR_BYTES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || cs_rise) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= ST_OPC;
                    end
                end
                ST_OPC: begin
                    if (byte_end) begin
                        case (byte_in)
                            OP_LATCH_SET, OP_LATCH_CLR: state_reg <= ST_WAIT;
                            OP_STAT_READ:             state_reg <= ST_STAT;
                            OP_STAT_WRITE:            state_reg <= ST_DATA;
                            OP_ARR_WRITE, OP_ID_WRITE: state_reg <= ST_ADDR;
                            OP_ARR_READ, OP_ID_READ:  state_reg <= busy_reg ? ST_IGNORE : ST_ADDR;
                            default:                  state_reg <= ST_IGNORE;
                        endcase
                    end
                end
                ST_ADDR: begin
                    if (addr_done) begin
                        state_reg <= (op_reg[0]) ? ST_STREAM : ST_DATA;
                    end
                end
                ST_WAIT: begin
                    if (sck_rise) begin
                        state_reg <= ST_IGNORE;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Execution checks at deselect
    logic        latch_reg;
    logic        lock_reg;
    logic [1:0]  bp_reg;
    logic        hw_lock;
    logic        in_data;
    logic        arr_guarded;
    logic        status_write_cmd_ok;
    logic        memw_ok;
    logic        idw_ok;

    assign hw_lock = lock_reg & ~wp_s;
    assign in_data = (state_reg == ST_DATA) && at_byte_reg && (data_cnt_reg != 2'h0) && latch_reg
                     && !busy_reg;

    // Guarded region per protect code
    always_comb begin
        case (bp_reg)
            BP_QUARTER: arr_guarded = (addr_reg[17:16] == QUARTER_TOP);
            BP_HALF:    arr_guarded = addr_reg[17];
            BP_ALL:     arr_guarded = 1'b1;
            default:    arr_guarded = 1'b0;
        endcase
    end

    assign status_write_cmd_ok = in_data && (op_reg == OP_STAT_WRITE) && (data_cnt_reg == 2'h1) && !hw_lock;
    assign memw_ok = in_data && (op_reg == OP_ARR_WRITE) && !arr_guarded;
    assign idw_ok  = in_data && (op_reg == OP_ID_WRITE) && (bp_reg != BP_ALL);

    ////////////////////////////////////////////////////////////////////////
    // Self-timed write cycle
    logic [31:0] tw_cnt_reg;
    logic        tw_done;

    assign tw_done = (tw_cnt_reg == 32'h1);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tw_cnt_reg <= 32'h0;
            busy_reg   <= 1'b0;
        end else if (cs_rise && (status_write_cmd_ok || memw_ok || idw_ok)) begin
            tw_cnt_reg <= 32'(TW_CYC);
            busy_reg   <= 1'b1;
        end else if (tw_cnt_reg != 32'h0) begin
            tw_cnt_reg <= tw_cnt_reg - 32'h1;
            busy_reg   <= !tw_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write latch; set wins over completion clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            latch_reg <= 1'b0;
        end else if (cs_rise && state_reg == ST_WAIT && op_reg == OP_LATCH_SET) begin
            latch_reg <= 1'b1;
        end else if (tw_done || (cs_rise && state_reg == ST_WAIT && op_reg == OP_LATCH_CLR)) begin
            latch_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Non-volatile protect bits, committed at cycle end
    logic        pend_reg;
    logic        pend_lock_reg;
    logic [1:0]  pend_bp_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_reg <= NV_LOCK_RESET;
            bp_reg   <= NV_BP_RESET;
            pend_reg <= 1'b0;
        end else if (cs_rise && status_write_cmd_ok) begin
            pend_reg      <= 1'b1;
            pend_lock_reg <= data_reg[BIT_LOCK];
            pend_bp_reg   <= data_reg[BIT_BP_HI:BIT_BP_LO];
        end else if (tw_done && pend_reg) begin
            pend_reg <= 1'b0;
            lock_reg <= pend_lock_reg;
            bp_reg   <= pend_bp_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status readout on falling edges
    logic [7:0]  stat_now;
    logic [7:0]  out_sh_reg;
    logic [2:0]  out_cnt_reg;

    assign stat_now = {lock_reg, 3'h0, bp_reg, latch_reg, busy_reg};

    always_ff @(posedge clk_sys) begin
        if (rst || state_reg != ST_STAT) begin
            link.miso_out <= 1'b0;
            link.miso_oe  <= 1'b0;
            out_cnt_reg   <= 3'h0;
            out_sh_reg    <= 8'h00;
        end else begin
            link.miso_oe <= 1'b1;
            if (sck_fall) begin
                out_cnt_reg <= out_cnt_reg + 3'h1;
                if (out_cnt_reg == 3'h0) begin
                    link.miso_out <= stat_now[7];
                    out_sh_reg    <= {stat_now[6:0], 1'b0};
                end else begin
                    link.miso_out <= out_sh_reg[7];
                    out_sh_reg    <= {out_sh_reg[6:0], 1'b0};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User-side outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_byte  <= 8'h00;
            hw_lock_mode <= 1'b0;
            arr_rd_go    <= 1'b0;
            arr_wr_go    <= 1'b0;
            arr_addr     <= 24'h0;
            id_go        <= 1'b0;
            id_kind      <= 2'h0;
        end else begin
            status_byte  <= stat_now;
            hw_lock_mode <= hw_lock;
            arr_rd_go    <= (state_reg == ST_ADDR) && addr_done && (op_reg == OP_ARR_READ);
            arr_wr_go    <= cs_rise && memw_ok;
            id_go        <= 1'b0;
            if ((state_reg == ST_ADDR) && addr_done) begin
                arr_addr <= addr_full;
                if (op_reg == OP_ID_READ) begin
                    id_go   <= 1'b1;
                    id_kind <= addr_full[ADDR_BIT_ID_SEL] ? ID_LOCK_READ : ID_PAGE_READ;
                end
            end else if (cs_rise && idw_ok) begin
                id_go   <= 1'b1;
                id_kind <= addr_reg[ADDR_BIT_ID_SEL] ? ID_LOCK_CMD : ID_PAGE_WRITE;
            end
        end
    end

endmodule : secp_dev

// ==== verilog/secp_pkg.sv ====
package secp_pkg;

    // Opcodes
    localparam logic [7:0] OP_LATCH_SET  = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
    localparam logic [7:0] OP_STAT_READ  = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE = 8'h01;
    localparam logic [7:0] OP_ARR_READ   = 8'h03;
    localparam logic [7:0] OP_ARR_WRITE  = 8'h02;
    localparam logic [7:0] OP_ID_READ    = 8'h83;
    localparam logic [7:0] OP_ID_WRITE   = 8'h82;

    // Status byte layout
    localparam int BIT_BUSY  = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 3;
    localparam int BIT_LOCK  = 7;
    localparam int ADDR_BIT_ID_SEL = 10;

    // Block-protect codes and protected address tops
    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;
    localparam logic [1:0] BP_ALL     = 2'h3;
    localparam logic [1:0] QUARTER_TOP = 2'h3;

    // Reset values of non-volatile bits (delivery state)
    localparam logic       NV_LOCK_RESET = 1'b0;
    localparam logic [1:0] NV_BP_RESET   = 2'h0;

    // Identification-page operation kinds
    localparam logic [1:0] ID_PAGE_READ  = 2'h0;
    localparam logic [1:0] ID_LOCK_READ  = 2'h1;
    localparam logic [1:0] ID_PAGE_WRITE = 2'h2;
    localparam logic [1:0] ID_LOCK_CMD   = 2'h3;

    // Timing
    localparam int CLK_MHZ   = 250;
    localparam int TW_US     = 5000;
    localparam int TW_CYCLES = TW_US * CLK_MHZ;
    localparam int HOST_HALF_DIV = 4;
    localparam int ADDR_BYTES    = 3;

    // Device protocol states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_OPC    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_DATA   = 3'b011,
        ST_WAIT   = 3'b100,
        ST_STAT   = 3'b101,
        ST_STREAM = 3'b110,
        ST_IGNORE = 3'b111
    } secp_state_t;

    // Host link states
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LOW  = 2'b01,
        H_HIGH = 2'b10,
        H_GAP  = 2'b11
    } secp_hstate_t;

endpackage : secp_pkg

// ==== verilog/secp_if.sv ====
`timescale 1ns/1ns
interface secp_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic wp_n;
    logic miso_out;
    logic miso_oe;
    wire  miso_pin;

    // Output pin resolution; undriven line floats high
    assign miso_pin = miso_oe ? miso_out : 1'b1;

    modport dev  (input cs_n, sck, mosi, wp_n, miso_pin, output miso_out, miso_oe);
    modport host (output cs_n, sck, mosi, wp_n, input miso_pin, miso_oe);
endinterface : secp_if

// ==== verilog/secp_host.sv ====
`timescale 1ns/1ns
module secp_host
    import secp_pkg::*;
#(
    parameter int unsigned HALF_DIV = HOST_HALF_DIV
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Serial link
    secp_if.host             link,
    // Command request
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [2:0]  cmd_nbytes,
    input  wire logic [39:0] cmd_bits,
    input  wire logic        wp_level,
    // Response
    output logic             rsp_valid,
    output logic [7:0]       rsp_byte
);

    if (HALF_DIV < 4 || HALF_DIV > 255) begin : g_bad_div
        $error("HALF_DIV must be 4 to 255");
    end

    ////////////////////////////////////////////////////////////////////////
    // Return data synchroniser
    logic        miso_meta_reg;
    logic        miso_sync_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            miso_meta_reg <= 1'b0;
            miso_sync_reg <= 1'b0;
        end else begin
            miso_meta_reg <= link.miso_pin;
            miso_sync_reg <= miso_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Half-period divider
    secp_hstate_t hst_reg;
    logic [7:0]  div_reg;
    logic        tick;

    assign tick = (div_reg == 8'(HALF_DIV - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || hst_reg == H_IDLE || tick) begin
            div_reg <= 8'h0;
        end else begin
            div_reg <= div_reg + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer, mode 0, MSB first
    logic [39:0] tx_reg;
    logic [5:0]  bits_left_reg;
    logic [7:0]  rx_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hst_reg       <= H_IDLE;
            link.cs_n     <= 1'b1;
            link.sck      <= 1'b0;
            link.mosi     <= 1'b0;
            link.wp_n     <= 1'b1;
            cmd_ready     <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_byte      <= 8'h00;
            tx_reg        <= 40'h0;
            rx_reg        <= 8'h00;
            bits_left_reg <= 6'h0;
        end else begin
            link.wp_n <= wp_level;
            rsp_valid <= 1'b0;
            case (hst_reg)
                H_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready     <= 1'b0;
                        link.cs_n     <= 1'b0;
                        link.mosi     <= cmd_bits[39];
                        tx_reg        <= cmd_bits;
                        bits_left_reg <= {cmd_nbytes, 3'h0};
                        hst_reg       <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        link.sck      <= 1'b1;
                        bits_left_reg <= bits_left_reg - 6'h1;
                        hst_reg       <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        link.sck <= 1'b0;
                        rx_reg   <= {rx_reg[6:0], miso_sync_reg};
                        if (bits_left_reg == 6'h0) begin
                            link.cs_n <= 1'b1;
                            rsp_valid <= 1'b1;
                            rsp_byte  <= {rx_reg[6:0], miso_sync_reg};
                            hst_reg   <= H_GAP;
                        end else begin
                            tx_reg    <= {tx_reg[38:0], 1'b0};
                            link.mosi <= tx_reg[38];
                            hst_reg   <= H_LOW;
                        end
                    end
                end
                default: begin
                    if (tick) begin
                        hst_reg <= H_IDLE;
                    end
                end
            endcase
        end
    end

endmodule : secp_host

// ==== verif/secp_checker.sv ====
`timescale 1ns/1ns
module secp_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link signals
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic wp_n,
    input wire logic miso_out,
    input wire logic miso_oe
);
    logic [7:0] nrise_reg;
    logic       sck_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock rises counted within the current frame
    always_ff @(posedge clk_sys) begin
        sck_d_reg <= rst ? 1'b0 : sck;
        if (rst || cs_n)
            nrise_reg <= 8'h00;
        else if (sck && !sck_d_reg)
            nrise_reg <= nrise_reg + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Properties of the wire
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // One clock pulse: four cycles high, then low
    sequence high_phase_s;
        sck [*4] ##1 !sck;
    endsequence

    idle_clk_low_a: assert property (cs_n |-> !sck)
        else $error("clock high while deselected");
    high_phase_a: assert property ($rose(sck) |-> high_phase_s)
        else $error("clock high phase wrong length");
    low_phase_a: assert property ($fell(sck) |-> !sck [*4])
        else $error("clock low phase too short");
    mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("data in moved while clock high");
    cs_hold_a: assert property (sck && $past(sck) |-> $stable(cs_n))
        else $error("select moved while clock high");
    byte_frame_a: assert property ($rose(cs_n) |-> nrise_reg != 8'h00 && nrise_reg[2:0] == 3'h0)
        else $error("frame not whole bytes");
    oe_after_op_a: assert property ($rose(miso_oe) |-> nrise_reg == 8'h08)
        else $error("data out enabled at wrong bit");
    oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
        else $error("data out kept after deselect");
    oe_idle_a: assert property (cs_n [*8] |-> !miso_oe)
        else $error("data out driven while deselected");
    miso_hold_a: assert property (miso_oe && $past(miso_oe) && sck && $past(sck) |-> $stable(miso_out))
        else $error("data out moved while clock high");
endmodule : secp_checker

// ==== verif/test_spi_eeprom_cmd_status_protect.sv ====
`timescale 1ns/1ns
module test_spi_eeprom_cmd_status_protect;
    import secp_pkg::*;
    logic        clk_sys;
    logic        rst;
    logic        cmd_valid;
    logic        cmd_ready;
    logic [2:0]  cmd_nbytes;
    logic [39:0] cmd_bits;
    logic        wp_level;
    logic        rsp_valid;
    logic [7:0]  rsp_byte;
    logic [7:0]  status_byte;
    logic        hw_lock_mode;
    logic [7:0]  got;
    logic [7:0]  d;
    logic        lk;
    logic [1:0]  bp;
    logic        ok;
    logic        arr_wr_go;
    logic [23:0] arr_addr;
    logic [23:0] a;
    logic        gd;
    int          n_wr;
    int          n_base;
    int          n_fail;
    int          compares;

    secp_if link ();
    secp_dev #(.TW_CYC(400)) u_secp_dev (.clk_sys(clk_sys), .rst(rst), .link(link.dev),
        .status_byte(status_byte), .hw_lock_mode(hw_lock_mode), .arr_rd_go(), .arr_wr_go(arr_wr_go),
        .arr_addr(arr_addr), .id_go(), .id_kind());
    secp_host #(.HALF_DIV(4)) u_secp_host (.clk_sys(clk_sys), .rst(rst), .link(link.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_nbytes(cmd_nbytes), .cmd_bits(cmd_bits),
        .wp_level(wp_level), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
    secp_checker u_secp_checker (.clk_sys(clk_sys), .rst(rst), .cs_n(link.cs_n), .sck(link.sck),
        .mosi(link.mosi), .wp_n(link.wp_n), .miso_out(link.miso_out), .miso_oe(link.miso_oe));

    ////////////////////////////////////////////////////////////////////////////
    // Clock source
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Accepted array writes seen on the pulse output
    always @(posedge clk_sys) begin
        if (arr_wr_go === 1'b1)
            n_wr <= n_wr + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] exp_st(input logic l, input logic [1:0] b, input logic w, input logic y);
        return {l, 3'h0, b, w, y};
    endfunction : exp_st

    // Region refused by each protect code
    function automatic logic guarded(input logic [1:0] b, input logic [23:0] ad);
        return (b == BP_ALL) || (b == BP_HALF && ad[17]) || (b == BP_QUARTER && ad[17:16] == 2'h3);
    endfunction : guarded

    task automatic tally_and_finish;
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic chk_addr(input logic [23:0] ga, input logic [23:0] ea);
        compares++;
        if (ga !== ea) begin
            n_fail++;
            $display("ERROR %0t: address %h expected %h", $time, ga, ea);
        end
    endtask : chk_addr

    task automatic stall;
        n_fail++;
        $display("ERROR %0t: wait ran out", $time);
        tally_and_finish();
    endtask : stall

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick

    // One frame through the host; keeps the last byte seen on the data out line
    task automatic xfer(input logic [2:0] n, input logic [39:0] b);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 100) begin
            tick();
            k++;
        end
        if (k == 100)
            stall();
        cmd_nbytes = n;
        cmd_bits   = b;
        cmd_valid  = 1'b1;
        tick();
        cmd_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 400) begin
            tick();
            k++;
        end
        if (k == 400)
            stall();
        got = rsp_byte;
    endtask : xfer

    task automatic rd;
        xfer(3'h3, {OP_STAT_READ, 32'h0});
    endtask : rd

    // Polls status until the timed cycle is over
    task automatic settle;
        int k;
        k = 0;
        while (got[0] !== 1'b0 && k < 8) begin
            rd();
            k++;
        end
        if (got[0] !== 1'b0)
            stall();
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst        = 1'b1;
        cmd_valid  = 1'b0;
        cmd_nbytes = 3'h1;
        cmd_bits   = 40'h0;
        wp_level   = 1'b1;
        n_fail     = 0;
        compares   = 0;
        lk         = 1'b0;
        bp         = 2'h0;
        void'($urandom(32'h8b60));
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        rd();
        chk(got, 8'h00);
        xfer(3'h2, {OP_LATCH_SET, 32'h0});
        rd();
        chk(got, 8'h00);
        xfer(3'h2, {OP_STAT_WRITE, 8'h8c, 24'h0});
        rd();
        chk(got, 8'h00);
        xfer(3'h1, {OP_LATCH_SET, 32'h0});
        rd();
        chk(got, 8'h02);
        xfer(3'h3, {OP_STAT_WRITE, 8'h8c, 24'h0});
        rd();
        chk(got, 8'h02);
        xfer(3'h3, {8'hff, 32'h0});
        chk(got, 8'hff);
        xfer(3'h1, {OP_LATCH_CLR, 32'h0});
        rd();
        chk(got, 8'h00);
        // Random status writes against random protect pin levels
        for (int i = 0; i < 12; i++) begin
            d        = 8'($urandom());
            wp_level = 1'($urandom());
            ok       = !(lk && !wp_level);
            xfer(3'h1, {OP_LATCH_SET, 32'h0});
            xfer(3'h2, {OP_STAT_WRITE, d, 24'h0});
            rd();
            chk(got, exp_st(lk, bp, 1'b1, ok));
            settle();
            if (ok) begin
                lk = d[7];
                bp = d[3:2];
            end
            chk(got, exp_st(lk, bp, !ok, 1'b0));
            chk(status_byte, exp_st(lk, bp, !ok, 1'b0));
            chk({7'h0, hw_lock_mode}, {7'h0, lk && !wp_level});
            if (!ok)
                xfer(3'h1, {OP_LATCH_CLR, 32'h0});
        end
        // Array writes against every protect code and region
        wp_level = 1'b1;
        for (int c = 0; c < 4; c++) begin
            xfer(3'h1, {OP_LATCH_SET, 32'h0});
            xfer(3'h2, {OP_STAT_WRITE, 4'h0, 2'(c), 2'h0, 24'h0});
            settle();
            lk = 1'b0;
            bp = 2'(c);
            chk(got, exp_st(lk, bp, 1'b0, 1'b0));
            for (int j = 0; j < 4; j++) begin
                a      = {6'($urandom()), 2'(j), 16'($urandom())};
                gd     = guarded(bp, a);
                n_base = n_wr;
                xfer(3'h1, {OP_LATCH_SET, 32'h0});
                xfer(3'h5, {OP_ARR_WRITE, a, 8'($urandom())});
                chk_addr(arr_addr, a);
                rd();
                chk(got, exp_st(lk, bp, 1'b1, !gd));
                settle();
                chk(got, exp_st(lk, bp, gd, 1'b0));
                chk(8'(n_wr - n_base), {7'h0, !gd});
                if (gd)
                    xfer(3'h1, {OP_LATCH_CLR, 32'h0});
            end
        end
        tally_and_finish();
    end
endmodule : test_spi_eeprom_cmd_status_protect
